// >>> design/ucm_core.sv
`default_nettype none
module ucm_core
   import ucm_pkg::*;
#(
   parameter int HoldCycles = HOLD_CYCLES_DEF,
   parameter int ScanCycles = SCAN_CYCLES_DEF
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   output logic [DATA_W-1:0] regRdData,
   input wire logic firstInputChannel,
   input wire logic secondInputChannel,
   input wire logic remoteStartStop,
   output ucm_disp_t disp,
   output logic gateOut
);
   localparam int HOLD_W = $clog2(HoldCycles);
   localparam int SCAN_W = $clog2(ScanCycles);
   localparam int TB_W = $clog2(TB_DIV);

   if (HoldCycles < 2 || ScanCycles < 2 || TB_DIV < 2) begin : g_check
      $error("ucm_core: hold, scan and time base counts must be at least 2");
   end

   // Pin synchronisers; inputs are sampled at the system clock rate
   logic [1:0] aSync_reg;
   logic [1:0] bSync_reg;
   logic [1:0] remSync_reg;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aSync_reg <= 2'h0;
         bSync_reg <= 2'h0;
         remSync_reg <= 2'h0;
      end else begin
         aSync_reg <= {aSync_reg[0], firstInputChannel};
         bSync_reg <= {bSync_reg[0], secondInputChannel};
         remSync_reg <= {remSync_reg[0], remoteStartStop};
      end
   end

   // Control register
   ucm_mode_t mode_reg;
   logic [2:0] averagingCountSetting_reg;
   logic slopeA_reg;
   logic slopeB_reg;
   logic panelStart_reg;
   logic clearReq_reg;
   logic modeChange_reg;
   logic avgChange_reg;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_reg <= MODE_FREQ;
         averagingCountSetting_reg <= AVG_RESET;
         slopeA_reg <= 1'b0;
         slopeB_reg <= 1'b0;
         panelStart_reg <= 1'b0;
         clearReq_reg <= 1'b0;
         modeChange_reg <= 1'b0;
         avgChange_reg <= 1'b0;
      end else begin
         clearReq_reg <= 1'b0;
         modeChange_reg <= 1'b0;
         avgChange_reg <= 1'b0;
         if (regWr && regAddr == REG_CTRL) begin
            mode_reg <= ucm_mode_t'(regWrData[CTRL_MODE_LSB +: 4]);
            averagingCountSetting_reg <= regWrData[CTRL_AVG_LSB +: 3];
            slopeA_reg <= regWrData[CTRL_SLOPE_A];
            slopeB_reg <= regWrData[CTRL_SLOPE_B];
            panelStart_reg <= regWrData[CTRL_START];
            clearReq_reg <= regWrData[CTRL_CLEAR];
            modeChange_reg <= regWrData[CTRL_MODE_LSB +: 4] != mode_reg;
            avgChange_reg <= regWrData[CTRL_AVG_LSB +: 3] != averagingCountSetting_reg;
         end
      end
   end

   // Mode decode
   logic isAvg;
   logic isWidth;
   logic isInterval;
   logic manualGate;
   logic countFirst;
   logic countDivided;
   always_comb begin
      isAvg = mode_reg inside {MODE_PERIOD_AVG, MODE_WIDTH_AVG, MODE_INTERVAL_AVG,
                               MODE_EVENTS_DURING, MODE_RATIO};
      isWidth = mode_reg inside {MODE_WIDTH, MODE_WIDTH_AVG, MODE_INTERVAL,
                                 MODE_INTERVAL_AVG, MODE_EVENTS_DURING};
      isInterval = mode_reg inside {MODE_INTERVAL, MODE_INTERVAL_AVG};
      manualGate = mode_reg inside {MODE_ACCUMULATE_EVENTS, MODE_MANUAL};
      countFirst = mode_reg inside {MODE_FREQ, MODE_EVENTS_DURING, MODE_RATIO,
                                    MODE_ACCUMULATE_EVENTS};
      countDivided = mode_reg inside {MODE_PERIOD, MODE_WIDTH, MODE_INTERVAL, MODE_MANUAL};
   end

   // Slope selection and edge detection
   logic aLvl;
   logic bLvl;
   logic aPrev_reg;
   logic bPrev_reg;
   logic remPrev_reg;
   logic aRise;
   logic bRise;
   // [R09] Slope picks portion
   assign aLvl = aSync_reg[1] ^ slopeA_reg;
   assign bLvl = bSync_reg[1] ^ slopeB_reg;
   assign aRise = aLvl & ~aPrev_reg;
   assign bRise = bLvl & ~bPrev_reg;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         aPrev_reg <= 1'b0;
         bPrev_reg <= 1'b0;
         remPrev_reg <= 1'b0;
      end else begin
         aPrev_reg <= aLvl;
         bPrev_reg <= bLvl;
         remPrev_reg <= remSync_reg[1];
      end
   end

   // Time base tick, one per 100 ns
   logic [TB_W-1:0] tbCnt_reg;
   logic tbTick;
   assign tbTick = tbCnt_reg == TB_W'(TB_DIV - 1);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         tbCnt_reg <= '0;
      end else begin
         tbCnt_reg <= tbTick ? '0 : tbCnt_reg + 1'b1;
      end
   end

   ucm_state_t state_reg;
   logic gateOpen_reg;
   logic gateDone_reg;
   logic interval_reg;
   logic pulsePrev_reg;
   logic armed;
   assign armed = state_reg == ST_ARM || state_reg == ST_MEASURE;

   // [R10] Interval pulse generator
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         interval_reg <= 1'b0;
      end else if (state_reg == ST_CLEAR) begin
         interval_reg <= 1'b0;
      end else if (armed && !interval_reg && aRise) begin
         interval_reg <= 1'b1;
      end else if (interval_reg && bRise) begin
         interval_reg <= 1'b0;
      end
   end

   logic pulseLvl;
   logic pulseRise;
   logic pulseFall;
   assign pulseLvl = isInterval ? interval_reg : bLvl;
   assign pulseRise = pulseLvl & ~pulsePrev_reg;
   assign pulseFall = ~pulseLvl & pulsePrev_reg;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         pulsePrev_reg <= 1'b0;
      end else begin
         pulsePrev_reg <= pulseLvl;
      end
   end

   // Decade divider
   logic [23:0] divCnt_reg;
   logic divIn;
   logic divOut;
   always_comb begin
      case (mode_reg)
         MODE_PERIOD_AVG, MODE_RATIO: divIn = pulseRise & gateOpen_reg;
         // [R13] Events gate by widths
         MODE_WIDTH_AVG, MODE_INTERVAL_AVG, MODE_EVENTS_DURING: begin
            divIn = pulseFall & gateOpen_reg;
         end
         MODE_ACCUMULATE_EVENTS: divIn = 1'b0;
         default: divIn = tbTick;
      endcase
   end
   // [R24] One out per ten-to-n in
   assign divOut = divIn && divCnt_reg == ucm_pow10(averagingCountSetting_reg) - 24'h000001;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         divCnt_reg <= '0;
      end else if (state_reg == ST_CLEAR || divOut) begin
         divCnt_reg <= '0;
      end else if (divIn) begin
         divCnt_reg <= divCnt_reg + 24'h000001;
      end
   end

   // Gate generator
   logic gateOpenEv;
   logic gateCloseEv;
   always_comb begin
      // [R01] Frequency gate from divider
      gateOpenEv = !gateOpen_reg && !gateDone_reg && state_reg == ST_ARM && !manualGate &&
                   (mode_reg == MODE_FREQ ? divOut : pulseRise);
      gateCloseEv = 1'b0;
      if (gateOpen_reg) begin
         if (mode_reg == MODE_FREQ || isAvg) begin
            // [R06] Ten-to-n gate
            gateCloseEv = divOut;
         end else if (mode_reg == MODE_PERIOD) begin
            // [R05] One period
            gateCloseEv = pulseRise;
         end else begin
            // [R07] One width
            gateCloseEv = pulseFall;
         end
      end
   end
   // [R22] Rise once, fall once
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         gateOpen_reg <= 1'b0;
         gateDone_reg <= 1'b0;
      end else if (state_reg == ST_CLEAR) begin
         gateOpen_reg <= 1'b0;
         gateDone_reg <= 1'b0;
      end else if (gateCloseEv) begin
         gateOpen_reg <= 1'b0;
         gateDone_reg <= 1'b1;
      end else if (gateOpenEv) begin
         gateOpen_reg <= 1'b1;
      end
   end

   // Start/stop: remote level change toggles the manual timer
   logic remoteToggle_reg;
   logic runLvl;
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         remoteToggle_reg <= 1'b0;
      end else if (remSync_reg[1] != remPrev_reg) begin
         remoteToggle_reg <= ~remoteToggle_reg;
      end
   end
   // [R16] Panel or remote change
   assign runLvl = mode_reg == MODE_MANUAL ? panelStart_reg ^ remoteToggle_reg
                                           : panelStart_reg | remSync_reg[1];

   logic gateActive;
   logic countSrc;
   logic countEv;
   always_comb begin
      // [R15] Manual gate modes
      gateActive = manualGate ? runLvl : gateOpen_reg;
      if (countFirst) begin
         // [R14] Count first channel
         countSrc = aRise;
      end else if (countDivided) begin
         // [R11] Divided time base
         countSrc = divOut;
      end else begin
         // [R12] Raw time base
         countSrc = tbTick;
      end
      // [R08] Only during pulse
      countEv = countSrc & gateActive & (!isWidth | pulseLvl);
   end

   // Accumulator: stages 0 and 1 plus six-decade unit
   logic [3:0] cnt_reg [DIGITS];
   logic [3:0] cntNext [DIGITS];
   logic carryOut;
   logic ovf_reg;
   logic cntReset;
   // [R23] Setting change clears
   assign cntReset = state_reg == ST_RESET || clearReq_reg || modeChange_reg ||
                     (mode_reg == MODE_MANUAL && avgChange_reg);
   // [R02] Eight decade carry chain
   always_comb begin
      logic carry;
      carry = countEv;
      for (int i = 0; i < DIGITS; i++) begin
         if (carry && cnt_reg[i] == 4'h9) begin
            cntNext[i] = 4'h0;
         end else begin
            cntNext[i] = cnt_reg[i] + {3'h0, carry};
            carry = 1'b0;
         end
      end
      carryOut = carry;
   end
   // [R21] Overflow, counting continues
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < DIGITS; i++) begin
            cnt_reg[i] <= 4'h0;
         end
         ovf_reg <= 1'b0;
      end else if (cntReset) begin
         for (int i = 0; i < DIGITS; i++) begin
            cnt_reg[i] <= 4'h0;
         end
         ovf_reg <= 1'b0;
      end else begin
         cnt_reg <= cntNext;
         ovf_reg <= ovf_reg | carryOut;
      end
   end

   // Measurement cycle timing
   logic [HOLD_W-1:0] holdCnt_reg;
   // [R04] Clear, latch, reset, hold
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_CLEAR;
      end else if (modeChange_reg || avgChange_reg || clearReq_reg) begin
         state_reg <= ST_CLEAR;
      end else begin
         case (state_reg)
            ST_CLEAR: state_reg <= ST_ARM;
            ST_ARM: state_reg <= gateOpenEv ? ST_MEASURE : ST_ARM;
            ST_MEASURE: state_reg <= gateCloseEv ? ST_LOAD : ST_MEASURE;
            ST_LOAD: state_reg <= ST_RESET;
            ST_RESET: state_reg <= ST_HOLD;
            ST_HOLD: begin
               if (holdCnt_reg == HOLD_W'(HoldCycles - 1)) begin
                  state_reg <= ST_CLEAR;
               end
            end
            default: state_reg <= ST_CLEAR;
         endcase
      end
   end
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         holdCnt_reg <= '0;
      end else if (state_reg == ST_HOLD) begin
         holdCnt_reg <= holdCnt_reg + 1'b1;
      end else begin
         holdCnt_reg <= '0;
      end
   end

   // Display latch; manual gate modes track the running total
   logic [3:0] latch_reg [DIGITS];
   logic latchOvf_reg;
   // [R25] Hold latched count
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < DIGITS; i++) begin
            latch_reg[i] <= 4'h0;
         end
         latchOvf_reg <= 1'b0;
      end else if (state_reg == ST_LOAD || (manualGate && state_reg == ST_ARM)) begin
         // [R03] Latch at gate end
         latch_reg <= cnt_reg;
         latchOvf_reg <= ovf_reg;
      end
   end

   // [R20] Point and annunciator lookup
   logic [2:0] dpPos;
   logic [3:0] annunLook;
   always_comb begin
      dpPos = 3'h0;
      annunLook = 4'h0;
      case (mode_reg)
         MODE_FREQ: begin
            dpPos = averagingCountSetting_reg == 3'h0 ? 3'h0 : averagingCountSetting_reg - 3'h1;
            annunLook = 4'h1;
         end
         MODE_PERIOD_AVG, MODE_WIDTH_AVG, MODE_INTERVAL_AVG: begin
            dpPos = averagingCountSetting_reg == 3'h7 ? 3'h7 : averagingCountSetting_reg + 3'h1;
            annunLook = 4'h2;
         end
         MODE_PERIOD, MODE_WIDTH, MODE_INTERVAL, MODE_MANUAL: begin
            dpPos = averagingCountSetting_reg == 3'h0 ? 3'h1 : 3'h0;
            annunLook = 4'h2;
         end
         MODE_RATIO, MODE_EVENTS_DURING: begin
            dpPos = averagingCountSetting_reg;
            annunLook = 4'h4;
         end
         default: annunLook = 4'h8;
      endcase
   end

   // [R19] Leading zero blanking
   logic [2:0] topDigit;
   always_comb begin
      topDigit = dpPos;
      for (int i = 0; i < DIGITS; i++) begin
         if (latch_reg[i] != 4'h0 && 3'(i) > topDigit) begin
            topDigit = 3'(i);
         end
      end
   end

   // [R18] Scan oscillator and time slots
   logic [SCAN_W-1:0] scanCnt_reg;
   logic [2:0] slot_reg;
   logic scanStep;
   assign scanStep = scanCnt_reg == SCAN_W'(ScanCycles - 1);
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         scanCnt_reg <= '0;
         slot_reg <= 3'h0;
      end else begin
         scanCnt_reg <= scanStep ? '0 : scanCnt_reg + 1'b1;
         if (scanStep) begin
            slot_reg <= slot_reg + 3'h1;
         end
      end
   end
   // [R17] Multiplexed digit output
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         disp <= DISP_RESET;
      end else begin
         // Toggle with the shown slot so scan clock and slot move on one edge
         if (slot_reg != disp.slot) begin
            disp.scanClk <= ~disp.scanClk;
         end
         disp.overflow <= latchOvf_reg;
         disp.slot <= slot_reg;
         disp.bcd <= latch_reg[slot_reg];
         disp.blank <= slot_reg > topDigit;
         disp.dp <= dpPos != 3'h0 && slot_reg == dpPos;
         disp.annun <= {latchOvf_reg, gateActive, annunLook};
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         gateOut <= 1'b0;
      end else begin
         gateOut <= gateActive;
      end
   end

   // Register read port; unmapped offsets read zero
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         regRdData <= '0;
      end else if (regRd) begin
         if (regAddr == REG_CTRL) begin
            regRdData <= {20'h00000, 1'b0, panelStart_reg, slopeB_reg, slopeA_reg,
                          1'b0, averagingCountSetting_reg, mode_reg};
         end else if (regAddr == REG_STATUS) begin
            regRdData <= {26'h0000000, state_reg, ovf_reg, gateDone_reg, gateActive};
         end else if (regAddr == REG_RESULT) begin
            regRdData <= {latch_reg[7], latch_reg[6], latch_reg[5], latch_reg[4],
                          latch_reg[3], latch_reg[2], latch_reg[1], latch_reg[0]};
         end else if (regAddr == REG_LIVE) begin
            regRdData <= {cnt_reg[7], cnt_reg[6], cnt_reg[5], cnt_reg[4],
                          cnt_reg[3], cnt_reg[2], cnt_reg[1], cnt_reg[0]};
         end else begin
            regRdData <= '0;
         end
      end else begin
         regRdData <= '0;
      end
   end
endmodule : ucm_core
`default_nettype wire

// >>> design/ucm_pkg.sv
// Functional notes
// [R01] Frequency: first channel counted directly, divided time base forms the gate.
// [R02] Accumulator is two decade count stages plus six decades, eight in total.
// [R03] At gate end the count is latched and shown with point and annunciator.
// [R04] Cycle timing: hold display, clear gate, latch counters, then reset counters.
// [R05] Period: count divided time base over exactly one second channel period.
// [R06] Averaged period: count raw time base, gate spans ten-to-n second periods.
// [R07] Width: count divided time base for one second channel pulse width.
// [R08] Averaged width: raw time base counted over ten-to-n widths via divider.
// [R09] Width counting follows high or low portions per second channel slope.
// [R10] Interval pulse starts on first channel edge, ends on second, per slopes.
// [R11] Interval with variable clock: divided time base counted over one pulse.
// [R12] Averaged interval: divider forms gate of ten-to-n pulses, raw base counted.
// [R13] Events during B: time base off, first channel counted over ten-to-n widths.
// [R14] Ratio: time base off, first channel counted over ten-to-n second cycles.
// [R15] Accumulate events: first channel counted only while start/stop asserted.
// [R16] Manual timing: channels ignored, divided base counted, start/stop gates.
// [R17] Upper six decades with their latches form one counter/latch unit.
// [R18] Scan oscillator makes time slots, scan clock, overflow and BCD digit data.
// [R19] Leading zero digits of the shown result are blanked.
// [R20] Point position and four annunciators come from a mode and setting lookup.
// [R21] Past eight decades overflow lights and counting carries on.
// [R22] After clear, gate rises on first clock edge, falls on second, then stays low.
// [R23] Manual timing: changing the averaging setting resets the total to zero.
// [R24] Divider passes one edge per ten-to-the-n input edges, n from the setting.
// [R25] Display holds the last latched count while counting goes on. The two manual gate modes show the running total instead.
`default_nettype none
package ucm_pkg;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 4;
   localparam int DIGITS = 8;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic [ADDR_W-1:0] REG_RESULT = 4'h8;
   localparam logic [ADDR_W-1:0] REG_LIVE = 4'hC;
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_AVG_LSB = 4;
   localparam int CTRL_SLOPE_A = 8;
   localparam int CTRL_SLOPE_B = 9;
   localparam int CTRL_START = 10;
   localparam int CTRL_CLEAR = 11;
   localparam logic [2:0] AVG_RESET = 3'h0;
   localparam int CLK_PERIOD_NS = 25;
   localparam int TB_PERIOD_NS = 100;
   localparam int TB_DIV = TB_PERIOD_NS / CLK_PERIOD_NS;
   localparam int HOLD_TIME_MS = 100;
   localparam int HOLD_CYCLES_DEF = HOLD_TIME_MS * 1000000 / CLK_PERIOD_NS;
   localparam int SCAN_TIME_US = 250;
   localparam int SCAN_CYCLES_DEF = SCAN_TIME_US * 1000 / CLK_PERIOD_NS;

   typedef enum logic [3:0] {
      MODE_FREQ = 4'h0,
      MODE_PERIOD = 4'h1,
      MODE_PERIOD_AVG = 4'h2,
      MODE_WIDTH = 4'h3,
      MODE_WIDTH_AVG = 4'h4,
      MODE_INTERVAL = 4'h5,
      MODE_INTERVAL_AVG = 4'h6,
      MODE_EVENTS_DURING = 4'h7,
      MODE_RATIO = 4'h8,
      MODE_ACCUMULATE_EVENTS = 4'h9,
      MODE_MANUAL = 4'hA
   } ucm_mode_t;

   typedef enum logic [2:0] {
      ST_CLEAR = 3'h0,
      ST_ARM = 3'h1,
      ST_MEASURE = 3'h3,
      ST_LOAD = 3'h2,
      ST_RESET = 3'h6,
      ST_HOLD = 3'h7
   } ucm_state_t;

   typedef struct packed {
      logic scanClk;
      logic overflow;
      logic [2:0] slot;
      logic [3:0] bcd;
      logic blank;
      logic dp;
      logic [5:0] annun;
   } ucm_disp_t;

   localparam ucm_disp_t DISP_RESET = '0;

   function automatic logic [23:0] ucm_pow10(input logic [2:0] n);
      case (n)
         3'h0: ucm_pow10 = 24'h000001;
         3'h1: ucm_pow10 = 24'h00000A;
         3'h2: ucm_pow10 = 24'h000064;
         3'h3: ucm_pow10 = 24'h0003E8;
         3'h4: ucm_pow10 = 24'h002710;
         3'h5: ucm_pow10 = 24'h0186A0;
         3'h6: ucm_pow10 = 24'h0F4240;
         default: ucm_pow10 = 24'h989680;
      endcase
   endfunction : ucm_pow10
endpackage : ucm_pkg
`default_nettype wire

// >>> tb/ucm_core_chk_asserts.sv
`default_nettype none
module ucm_core_chk
   import ucm_pkg::*;
(
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [ADDR_W-1:0] regAddr,
   input wire logic [DATA_W-1:0] regWrData,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [DATA_W-1:0] regRdData,
   input wire logic firstInputChannel,
   input wire logic secondInputChannel,
   input wire logic remoteStartStop,
   input wire ucm_disp_t disp,
   input wire logic gateOut
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   logic mapped;
   assign mapped = regAddr inside {REG_CTRL, REG_STATUS, REG_RESULT, REG_LIVE};
   AST_RD_IDLE: assert property (!$past(regRd) |-> regRdData == '0)
      else $error("read data not zero outside a read answer");
   AST_RD_UNMAPPED: assert property (regRd && !mapped |=> regRdData == '0)
      else $error("unmapped read returned data");
   AST_CLEAR_READS_ZERO: assert property (regRd && regAddr == REG_CTRL |=> !regRdData[11])
      else $error("clear bit read back as one");
   AST_BLANK_ZERO: assert property (disp.blank |-> disp.bcd == 4'h0)
      else $error("blanked digit is not zero");
   AST_UNITS_SHOWN: assert property (disp.slot == 3'h0 |-> !disp.blank)
      else $error("least digit blanked");
   AST_OVF_ANNUN: assert property (disp.annun[5] == disp.overflow)
      else $error("overflow annunciator differs from overflow");
   AST_LOOKUP_ONE: assert property ($onehot0(disp.annun[3:0]))
      else $error("more than one lookup annunciator lit");
   AST_SLOT_STEP: assert property ($changed(disp.slot) |->
      disp.slot == $past(disp.slot) + 3'h1 && $changed(disp.scanClk))
      else $error("time slot did not step by one with scan clock");
endmodule : ucm_core_chk
bind ucm_core ucm_core_chk u_chk (.clk(clk), .sys_rst(sys_rst), .regAddr(regAddr),
   .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
   .firstInputChannel(firstInputChannel), .secondInputChannel(secondInputChannel),
   .remoteStartStop(remoteStartStop), .disp(disp), .gateOut(gateOut));
`default_nettype wire

// >>> tb/ucm_chan_model.sv
`default_nettype none
module ucm_chan_model (
   input wire logic clk,
   input wire logic [15:0] aHalf,
   input wire logic [15:0] bHalf,
   input wire logic rmtReq,
   output logic chA,
   output logic chB,
   output logic rmt
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [15:0] aCnt = '0;
   logic [15:0] bCnt = '0;
   initial begin
      chA = 1'b0;
      chB = 1'b0;
      rmt = 1'b0;
   end
   // Comparators idle low when their source stops
   always @(posedge clk) begin
      aCnt <= (aHalf == '0 || aCnt >= aHalf - 16'h1) ? '0 : aCnt + 16'h1;
      chA <= (aHalf == '0) ? 1'b0 : chA ^ (aCnt >= aHalf - 16'h1);
      bCnt <= (bHalf == '0 || bCnt >= bHalf - 16'h1) ? '0 : bCnt + 16'h1;
      chB <= (bHalf == '0) ? 1'b0 : chB ^ (bCnt >= bHalf - 16'h1);
   end
   always @(posedge clk) begin
      rmt <= rmtReq;
   end
endmodule : ucm_chan_model
`default_nettype wire

// >>> tb/universal_counter_mode_routing_bench.sv
`default_nettype none
module universal_counter_mode_routing_bench;
   timeunit 1ns;
   timeprecision 100ps;
   import ucm_pkg::*;
   logic clk = 1'b0;
   logic sys_rst = 1'b1;
   logic [ADDR_W-1:0] regAddr = '0;
   logic [DATA_W-1:0] regWrData = '0;
   logic regWr = 1'b0;
   logic regRd = 1'b0;
   logic [DATA_W-1:0] regRdData;
   logic chA;
   logic chB;
   logic rmt;
   logic [15:0] aHalf = '0;
   logic [15:0] bHalf = '0;
   logic rmtReq = 1'b0;
   ucm_disp_t disp;
   logic gateOut;
   int err_count = 0;
   int checks_done = 0;
   // Ctrl word, lowest and highest count per averaged or timed mode
   // Averaged interval: first pulse may be cut short, nine full ones follow
   int modeTab[8] = '{32'h20, 32'h1, 32'h12, 32'h3, 32'h14, 32'h17, 32'h18, 32'h16};
   int loTab[8] = '{49, 99, 998, 49, 498, 240, 498, 870};
   int hiTab[8] = '{51, 101, 1002, 51, 502, 260, 502, 1010};
   always #12.5 clk = ~clk;
   ucm_core #(.HoldCycles(8), .ScanCycles(4)) DUT (.clk(clk), .sys_rst(sys_rst),
      .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
      .regRdData(regRdData), .firstInputChannel(chA), .secondInputChannel(chB),
      .remoteStartStop(rmt), .disp(disp), .gateOut(gateOut));
   ucm_chan_model PEER (.clk(clk), .aHalf(aHalf), .bHalf(bHalf), .rmtReq(rmtReq),
      .chA(chA), .chB(chB), .rmt(rmt));
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : results
   task automatic check(input logic ok, input string msg);
      checks_done++;
      if (ok !== 1'b1) begin
         err_count++;
         $display("CHECK FAILED at %0t: %s", $time, msg);
      end
   endtask : check
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1 d = regRdData;
   endtask : rd
   task automatic rdExp(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      logic [DATA_W-1:0] d;
      rd(a, d);
      check(d === e, "register value differs");
   endtask : rdExp
   task automatic rdNear(input logic [ADDR_W-1:0] a, input int lo, input int hi);
      logic [DATA_W-1:0] d;
      int r;
      rd(a, d);
      r = 0;
      for (int i = DIGITS - 1; i >= 0; i--) begin
         r = r * 10 + int'(d[i*4 +: 4]);
      end
      check((^d !== 1'bx) && r >= lo && r <= hi, "count out of range");
   endtask : rdNear
   task automatic waitDone();
      logic [DATA_W-1:0] s;
      int n;
      n = 0;
      do begin
         rd(REG_STATUS, s);
         n++;
      end while (s[1] !== 1'b1 && n < 8000);
      if (n >= 8000) begin
         err_count++;
         $display("CHECK FAILED at %0t: gate never finished", $time);
         results();
      end
   endtask : waitDone
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      rdExp(REG_CTRL, '0);
      rdExp(4'h2, '0);
      rdExp(REG_RESULT, '0);
      wr(REG_CTRL, 32'h409);
      aHalf <= 16'h4;
      repeat (40) @(posedge clk);
      aHalf <= '0;
      repeat (10) @(posedge clk);
      wr(REG_CTRL, 32'h9);
      rdExp(REG_RESULT, 32'h5);
      rdExp(REG_LIVE, 32'h5);
      wr(REG_CTRL, 32'h809);
      repeat (2) @(posedge clk);
      rdExp(REG_RESULT, '0);
      $display("accumulate test finished");
      wr(REG_CTRL, 32'hA);
      wr(REG_CTRL, 32'h40A);
      repeat (2) @(posedge clk);
      check(gateOut === 1'b1, "gate not open while started");
      repeat (398) @(posedge clk);
      wr(REG_CTRL, 32'hA);
      rdNear(REG_RESULT, 99, 101);
      check(gateOut === 1'b0, "gate still open after stop");
      @(posedge clk);
      rmtReq <= 1'b1;
      repeat (200) @(posedge clk);
      rmtReq <= 1'b0;
      repeat (10) @(posedge clk);
      rdNear(REG_RESULT, 148, 152);
      wr(REG_CTRL, 32'h1A);
      repeat (2) @(posedge clk);
      rdExp(REG_RESULT, '0);
      $display("manual timing test finished");
      aHalf <= 16'h4;
      bHalf <= 16'd200;
      foreach (modeTab[i]) begin
         wr(REG_CTRL, modeTab[i]);
         repeat (4) @(posedge clk);
         waitDone();
         repeat (4) @(posedge clk);
         rdNear(REG_RESULT, loTab[i], hiTab[i]);
      end
      $display("gated mode test finished");
      results();
   end
endmodule : universal_counter_mode_routing_bench
`default_nettype wire
